// ---- design/wdu_watchdog_unit.sv ----
// Watchdog unit: counter advanced by the slow counter oscillator, normal and
// window modes, early warning flag, clear key, write protection.
// Assumes the oscillator level arrives synchronous to mclk_in and that the
// system reset logic resets this block once a reset request is raised.
//
// Function
// - Missed clear before time-out raises reset
// - Optional early warning interrupt before time-out
// - Window mode: early or late clear resets
// - Counter keeps running in all power modes
// - Own oscillator keeps reset path alive
// - Normal time-out 8 to 16384 cycles
// - Window total 16 to 32768 cycles
// - Counter advanced by 1 kHz oscillator clock
// - Counting stops while processor debug-halted
// - Access controller may lock writes except flags
// - Debugger writes bypass the write lock
// - Control and keyed clear writes synchronised to oscillator
// - Mode from enable, window and interrupt enable
// - Interrupt can wake device from sleep
// - Key 0xA5 to clear restarts period
// - Any other clear value while enabled resets immediately
// - Disabled stops; enabled normal or window mode
// - Window early warning at open window start
`timescale 1ns/100ps

module wdu_watchdog_unit (
    // Clock and reset
    input wire logic mclk_in,
    input wire logic nrst_in,
    // Register port
    input wire logic [7:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    output logic [31:0] bus_rdata_out,
    // Counter oscillator level, sampled on mclk_in
    input wire logic osc_clk_in,
    // System side
    input wire logic cpu_debug_halt_in,
    input wire logic pac_protect_in,
    input wire logic debugger_access_in,
    // Outputs
    output logic sys_reset_req_out,
    output logic irq_out,
    output wdu_pkg::wdu_mode_t mode_out
);

    ////////////////////////////////////////////////////////////////////////
    // State

    typedef struct packed {
        logic enable;
        logic wen;
        logic [3:0] timeout_period_field;
        logic [3:0] window;
        logic [3:0] ewofs;
        logic inten;
        logic flag;
        logic [15:0] cnt;
        logic pend_ctrl;
        logic pend_en;
        logic pend_wen;
        logic pend_clear;
        logic osc_prev;
        logic rst_req;
        logic [31:0] rdata;
    } wdu_state_t;

    wdu_state_t s_reg;
    wdu_state_t s_next;

    ////////////////////////////////////////////////////////////////////////
    // Next state

    logic osc_rise;
    logic wr_allow;
    logic ew_evt;
    logic rst_evt;
    logic [15:0] closed_len;
    logic [15:0] open_len;
    logic [15:0] limit;
    logic [15:0] ew_point;
    logic [15:0] ew_len;
    logic [15:0] inc;

    // One decoder per period code; each length is a shift of the base length
    wdu_period_decode #(
        .OUT_W(wdu_pkg::CNT_W)
    ) u_closed_dec (
        .code_in(s_reg.window),
        .cycles_out(closed_len)
    );

    wdu_period_decode #(
        .OUT_W(wdu_pkg::CNT_W)
    ) u_open_dec (
        .code_in(s_reg.timeout_period_field),
        .cycles_out(open_len)
    );

    wdu_period_decode #(
        .OUT_W(wdu_pkg::CNT_W)
    ) u_warn_dec (
        .code_in(s_reg.ewofs),
        .cycles_out(ew_len)
    );

    always_comb begin
        s_next = s_reg;
        s_next.rdata = 32'h0000_0000;
        ew_evt = 1'b0;
        rst_evt = 1'b0;
        inc = 16'h0000;
        // Only rising edges of the slow oscillator advance anything
        osc_rise = osc_clk_in & ~s_reg.osc_prev;
        s_next.osc_prev = osc_clk_in;
        // Lock applies to software only; debugger keeps full access
        wr_allow = ~pac_protect_in | debugger_access_in;

        // Sum of two periods of 8..16384 stays within 16..32768
        limit = s_reg.wen ? 16'(closed_len + open_len) : open_len;
        ew_point = s_reg.wen ? closed_len : ew_len;

        // Oscillator domain work: pending writes land here
        if (osc_rise) begin
            if (s_reg.pend_ctrl) begin
                s_next.pend_ctrl = 1'b0;
                s_next.enable = s_reg.pend_en;
                s_next.wen = s_reg.pend_wen;
                if (s_reg.pend_en && !s_reg.enable) begin
                    s_next.cnt = 16'h0000;
                end
                if (!s_reg.pend_en) begin
                    s_next.pend_clear = 1'b0;
                end
            end else if (s_reg.enable && !cpu_debug_halt_in) begin
                if (s_reg.pend_clear) begin
                    s_next.pend_clear = 1'b0;
                    if (s_reg.wen && (s_reg.cnt < closed_len)) begin
                        rst_evt = 1'b1;
                    end else begin
                        s_next.cnt = 16'h0000;
                    end
                end else begin
                    inc = 16'(s_reg.cnt + 16'h0001);
                    if (inc >= limit) begin
                        // Time-out; also covers a clear arriving too late
                        rst_evt = 1'b1;
                    end else begin
                        s_next.cnt = inc;
                    end
                    // In normal mode an offset past the period never fires
                    if (inc == ew_point && ew_point < limit) begin
                        ew_evt = 1'b1;
                    end
                end
            end
        end

        // Register writes; these follow the tick so a new pending write survives
        // Strobes alone carry a write, so a gated bus clock loses nothing
        if (bus_wr_in) begin
            case (bus_addr_in)
                wdu_pkg::OFS_CONTROL_A: begin
                    if (wr_allow) begin
                        s_next.pend_ctrl = 1'b1;
                        s_next.pend_en = bus_wdata_in[wdu_pkg::BIT_ENABLE];
                        // Window bit is enable-protected while running
                        s_next.pend_wen = s_reg.enable ? s_reg.wen : bus_wdata_in[wdu_pkg::BIT_WEN];
                    end
                end
                wdu_pkg::OFS_CONFIG: begin
                    if (wr_allow && !s_reg.enable) begin
                        s_next.timeout_period_field = bus_wdata_in[wdu_pkg::PER_LSB +: wdu_pkg::CODE_W];
                        s_next.window = bus_wdata_in[wdu_pkg::WINDOW_LSB +: wdu_pkg::CODE_W];
                    end
                end
                wdu_pkg::OFS_EW_CTRL: begin
                    if (wr_allow && !s_reg.enable) begin
                        s_next.ewofs = bus_wdata_in[wdu_pkg::EWOFS_LSB +: wdu_pkg::CODE_W];
                    end
                end
                wdu_pkg::OFS_INT_EN_SET: begin
                    if (wr_allow && bus_wdata_in[wdu_pkg::BIT_EARLY_WARNING]) begin
                        s_next.inten = 1'b1;
                    end
                end
                wdu_pkg::OFS_INT_EN_CLR: begin
                    if (wr_allow && bus_wdata_in[wdu_pkg::BIT_EARLY_WARNING]) begin
                        s_next.inten = 1'b0;
                    end
                end
                wdu_pkg::OFS_INT_FLAG: begin
                    // Flag register ignores the write lock
                    if (bus_wdata_in[wdu_pkg::BIT_EARLY_WARNING]) begin
                        s_next.flag = 1'b0;
                    end
                end
                wdu_pkg::OFS_CLEAR: begin
                    if (wr_allow && s_reg.enable) begin
                        if (bus_wdata_in[7:0] == wdu_pkg::CLEAR_KEY) begin
                            s_next.pend_clear = 1'b1;
                        end else begin
                            // Bad key needs no synchronisation: act at once
                            s_next.rst_req = 1'b1;
                        end
                    end
                end
                default: begin
                end
            endcase
        end

        // A warning in the same cycle as a flag clear is kept
        if (ew_evt) begin
            s_next.flag = 1'b1;
        end
        if (rst_evt) begin
            s_next.rst_req = 1'b1;
        end

        // Register reads; data appear one cycle later
        if (bus_rd_in) begin
            case (bus_addr_in)
                wdu_pkg::OFS_CONTROL_A: begin
                    s_next.rdata[wdu_pkg::BIT_ENABLE] = s_reg.enable;
                    s_next.rdata[wdu_pkg::BIT_WEN] = s_reg.wen;
                end
                wdu_pkg::OFS_CONFIG: begin
                    s_next.rdata[wdu_pkg::PER_LSB +: wdu_pkg::CODE_W] = s_reg.timeout_period_field;
                    s_next.rdata[wdu_pkg::WINDOW_LSB +: wdu_pkg::CODE_W] = s_reg.window;
                end
                wdu_pkg::OFS_EW_CTRL: begin
                    s_next.rdata[wdu_pkg::EWOFS_LSB +: wdu_pkg::CODE_W] = s_reg.ewofs;
                end
                wdu_pkg::OFS_INT_EN_SET, wdu_pkg::OFS_INT_EN_CLR: begin
                    s_next.rdata[wdu_pkg::BIT_EARLY_WARNING] = s_reg.inten;
                end
                wdu_pkg::OFS_INT_FLAG: begin
                    s_next.rdata[wdu_pkg::BIT_EARLY_WARNING] = s_reg.flag;
                end
                wdu_pkg::OFS_STATUS: begin
                    s_next.rdata[wdu_pkg::BIT_SYNC_BUSY] = s_reg.pend_ctrl | s_reg.pend_clear;
                end
                default: begin
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            s_reg <= '0;
            s_reg.enable <= wdu_pkg::RST_ENABLE;
            s_reg.wen <= wdu_pkg::RST_WEN;
            s_reg.timeout_period_field <= wdu_pkg::RST_PER;
            s_reg.window <= wdu_pkg::RST_WINDOW;
            s_reg.ewofs <= wdu_pkg::RST_EWOFS;
        end else begin
            s_reg <= s_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs

    // Request needs no bus clock, so it can wake the device from sleep
    assign irq_out = s_reg.flag & s_reg.inten;
    assign sys_reset_req_out = s_reg.rst_req;
    assign bus_rdata_out = s_reg.rdata;

    always_comb begin
        if (!s_reg.enable) begin
            mode_out = wdu_pkg::WDU_STOPPED;
        end else begin
            case ({s_reg.wen, s_reg.inten})
                2'h0: mode_out = wdu_pkg::WDU_NORMAL;
                2'h1: mode_out = wdu_pkg::WDU_NORMAL_EW;
                2'h2: mode_out = wdu_pkg::WDU_WINDOW;
                2'h3: mode_out = wdu_pkg::WDU_WINDOW_EW;
                default: mode_out = wdu_pkg::WDU_STOPPED;
            endcase
        end
    end

endmodule

////////////////////////////////////////////////////////////////////////////
// Period decoder: code to length in counter ticks

module wdu_period_decode #(
    parameter int OUT_W = 16
) (
    // Period code
    input wire logic [3:0] code_in,
    // Length in counter ticks
    output logic [OUT_W-1:0] cycles_out
);

    logic [3:0] code_lim;

    // Codes above the largest legal one behave as the largest, so no
    // code can overflow the counter
    assign code_lim = (code_in > wdu_pkg::CODE_MAX) ? wdu_pkg::CODE_MAX : code_in;
    assign cycles_out = OUT_W'(wdu_pkg::PERIOD_BASE) << code_lim;

endmodule

// ---- include/wdu_pkg.sv ----
// Package for the watchdog unit: register map, field positions, reset
// values, period encoding and the operating mode type.
// Assumes a 32-bit register port with byte addresses on an 8-bit address.
package wdu_pkg;

    // Register byte offsets
    localparam logic [7:0] OFS_CONTROL_A = 8'h00;
    localparam logic [7:0] OFS_CONFIG = 8'h04;
    localparam logic [7:0] OFS_EW_CTRL = 8'h08;
    localparam logic [7:0] OFS_INT_EN_CLR = 8'h0C;
    localparam logic [7:0] OFS_INT_EN_SET = 8'h10;
    localparam logic [7:0] OFS_INT_FLAG = 8'h14;
    localparam logic [7:0] OFS_STATUS = 8'h18;
    localparam logic [7:0] OFS_CLEAR = 8'h1C;

    // Field positions
    localparam int BIT_ENABLE = 1;
    localparam int BIT_WEN = 2;
    localparam int BIT_EARLY_WARNING = 0;
    localparam int BIT_SYNC_BUSY = 0;
    localparam int PER_LSB = 0;
    localparam int WINDOW_LSB = 4;
    localparam int EWOFS_LSB = 0;
    localparam int CODE_W = 4;

    // Reset values
    localparam logic RST_ENABLE = 1'h0;
    localparam logic RST_WEN = 1'h0;
    localparam logic [3:0] RST_PER = 4'hB;
    localparam logic [3:0] RST_WINDOW = 4'hB;
    localparam logic [3:0] RST_EWOFS = 4'hB;

    // Clear key
    localparam logic [7:0] CLEAR_KEY = 8'hA5;

    // Period encoding: cycles = BASE << code, code limited to CODE_MAX
    localparam int CNT_W = 16;
    localparam logic [15:0] PERIOD_BASE = 16'h0008;
    localparam logic [3:0] CODE_MAX = 4'hB;

    typedef enum logic [2:0] {
        WDU_STOPPED,
        WDU_NORMAL,
        WDU_NORMAL_EW,
        WDU_WINDOW,
        WDU_WINDOW_EW
    } wdu_mode_t;

endpackage

// ---- testbench/testbench.sv ----
// Self-checking bench for the watchdog unit with a free oscillator model.
// Assumes the design and checker are compiled before this file.
`timescale 1ns/100ps
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin failures++; \
    $display("unexpected at %0t: got %0h exp %0h", $time, (g), (e)); end end
module testbench;
    logic mclk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic [7:0] bus_addr_in = 8'h00;
    logic [31:0] bus_wdata_in = 32'h0;
    logic bus_wr_in = 1'b0;
    logic bus_rd_in = 1'b0;
    logic cpu_debug_halt_in = 1'b0;
    logic pac_protect_in = 1'b0;
    logic debugger_access_in = 1'b0;
    logic osc_clk_in;
    logic [31:0] bus_rdata_out;
    logic sys_reset_req_out;
    logic irq_out;
    wdu_pkg::wdu_mode_t mode_out;
    int failures = 0;
    int n_checks = 0;
    int cycles = 0;
    int ti, tr, c;
    logic [31:0] rv;
    logic [7:0] key = wdu_pkg::CLEAR_KEY;
    logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h14, 8'h1C};
    logic [31:0] re [6] = '{32'h0, 32'hBB, 32'hB, 32'h0, 32'h0, 32'h0};
    always #4 mclk_in = ~mclk_in;
    wdu_osc_model #(.HALF(4)) osc (.mclk_in(mclk_in), .osc_out(osc_clk_in));
    wdu_watchdog_unit DUT (.*);
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            final_report();
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic final_report;
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk_in);
        bus_addr_in <= a;
        bus_wdata_in <= d;
        bus_wr_in <= 1'b1;
        @(posedge mclk_in);
        bus_wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge mclk_in);
        bus_addr_in <= a;
        bus_rd_in <= 1'b1;
        @(posedge mclk_in);
        bus_rd_in <= 1'b0;
        #1;
        d = bus_rdata_out;
    endtask
    task automatic rst;
        nrst_in <= 1'b0;
        repeat (8) @(posedge mclk_in);
        nrst_in <= 1'b1;
    endtask
    // Counts oscillator rises; ti and tr hold the count when irq and reset first show
    task automatic wait_ev(input int clr_at);
        int n;
        logic p;
        n = 0;
        ti = 0;
        tr = 0;
        p = osc_clk_in;
        repeat (600) begin
            @(posedge mclk_in);
            #1;
            if (osc_clk_in && !p) n++;
            p = osc_clk_in;
            if (irq_out === 1'b1 && ti == 0) ti = n;
            if (sys_reset_req_out === 1'b1 && tr == 0) tr = n;
            if (tr != 0) break;
            if (n == clr_at) begin
                wr(wdu_pkg::OFS_CLEAR, {24'h0, key});
                clr_at = -1;
            end
        end
    endtask
    // Enable is written just after an oscillator fall, far from the next tick
    task automatic run(input logic [3:0] cfg, input logic [31:0] ctl, input logic [3:0] ew, input logic ie,
        input int clr_at);
        rst();
        wr(wdu_pkg::OFS_CONFIG, {28'h0, cfg});
        wr(wdu_pkg::OFS_EW_CTRL, {28'h0, ew});
        wr(wdu_pkg::OFS_INT_EN_SET, {31'h0, ie});
        @(negedge osc_clk_in);
        wr(wdu_pkg::OFS_CONTROL_A, ctl);
        wait_ev(clr_at);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(29));
        rst();
        for (int i = 0; i < 6; i++) begin
            rd(ra[i], rv);
            `CHK(rv, re[i])
        end
        rd(8'h40, rv);
        `CHK(rv, 32'h0)
        `CHK(mode_out, wdu_pkg::WDU_STOPPED)
        for (int k = 0; k < 3; k++) begin
            c = $urandom_range(2, 1);
            run(4'(c), 32'h2, 4'(c - 1), 1'b1, -1);
            `CHK(mode_out, wdu_pkg::WDU_NORMAL_EW)
            `CHK(ti, 1 + (8 << (c - 1)))
            `CHK(tr, 1 + (8 << c))
            pac_protect_in <= 1'b1;
            wr(wdu_pkg::OFS_INT_FLAG, 32'h1);
            `CHK(irq_out, 1'b0)
            pac_protect_in <= 1'b0;
        end
        run(4'h1, 32'h2, 4'hB, 1'b0, 10);
        `CHK(tr, 10 + 1 + (8 << 1))
        run(4'h0, 32'h6, 4'h0, 1'b1, -1);
        `CHK(mode_out, wdu_pkg::WDU_WINDOW_EW)
        `CHK(ti, 1 + 8)
        `CHK(tr, 1 + 8 + 8)
        run(4'h0, 32'h6, 4'h0, 1'b0, 4);
        `CHK(tr, 4 + 1)
        run(4'h0, 32'h6, 4'h0, 1'b0, 12);
        `CHK(tr, 12 + 1 + 16)
        for (int k = 0; k < 3; k++) begin
            key = 8'($urandom_range(8'hA4, 8'h00));
            pac_protect_in <= (k != 0);
            debugger_access_in <= (k == 2);
            run(4'h1, 32'h2, 4'hB, 1'b0, 3);
            `CHK(tr, (k == 1) ? 0 : 3)
        end
        pac_protect_in <= 1'b0;
        debugger_access_in <= 1'b0;
        cpu_debug_halt_in <= 1'b1;
        run(4'h0, 32'h2, 4'hB, 1'b0, -1);
        `CHK(tr, 0)
        cpu_debug_halt_in <= 1'b0;
        wait_ev(-1);
        `CHK(tr, 8)
        final_report();
    end
endmodule
bind wdu_watchdog_unit wdu_watchdog_unit_sva chk (.*);

// ---- testbench/wdu_osc_model.sv ----
// Counter oscillator model: a free-running slow level for the watchdog unit.
// Assumes mclk_in is the bench clock; the level toggles every HALF cycles.
`timescale 1ns/100ps
module wdu_osc_model #(parameter int HALF = 4) (
    input wire logic mclk_in,
    output logic osc_out
);
    int cnt = 0;
    initial osc_out = 1'b0;
    // Runs on its own, shortened from 1 kHz to keep the run short
    always @(posedge mclk_in) begin
        if (cnt == HALF - 1) begin
            osc_out <= ~osc_out;
        end
        cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    end
endmodule

// ---- testbench/wdu_watchdog_unit_sva.sv ----
// Checker for the watchdog unit ports.
// Assumes it is bound to the top module and sees its ports only.
`timescale 1ns/100ps
module wdu_watchdog_unit_sva (
    input wire logic mclk_in,
    input wire logic nrst_in,
    input wire logic [7:0] bus_addr_in,
    input wire logic [31:0] bus_wdata_in,
    input wire logic bus_wr_in,
    input wire logic bus_rd_in,
    input wire logic [31:0] bus_rdata_out,
    input wire logic osc_clk_in,
    input wire logic cpu_debug_halt_in,
    input wire logic pac_protect_in,
    input wire logic debugger_access_in,
    input wire logic sys_reset_req_out,
    input wire logic irq_out,
    input wire wdu_pkg::wdu_mode_t mode_out
);
    logic sw_en_reg;
    logic wr_ok;
    assign wr_ok = bus_wr_in && (!pac_protect_in || debugger_access_in);
    // Tracks the enable that software last wrote, so a pending disable is not misread
    always_ff @(posedge mclk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sw_en_reg <= 1'b0;
        end else if (wr_ok && bus_addr_in == wdu_pkg::OFS_CONTROL_A) begin
            sw_en_reg <= bus_wdata_in[wdu_pkg::BIT_ENABLE];
        end
    end
    default clocking cb @(posedge mclk_in);
    endclocking
    default disable iff (!nrst_in);
    ////////////////////////////////////////////////////////////////////////////
    a_rdata_idle: assert property (!$past(bus_rd_in) |-> bus_rdata_out == 32'h0)
        else $error("read data outside the answer cycle");
    a_rdata_empty: assert property (bus_rd_in && (bus_addr_in > wdu_pkg::OFS_CLEAR ||
        bus_addr_in == wdu_pkg::OFS_CLEAR) |=> bus_rdata_out == 32'h0) else $error("unmapped read not zero");
    a_reset_sticky: assert property (sys_reset_req_out |=> sys_reset_req_out)
        else $error("reset request dropped");
    a_stop_quiet: assert property (mode_out == wdu_pkg::WDU_STOPPED && !sys_reset_req_out &&
        !bus_wr_in && !$past(bus_wr_in) |=> !sys_reset_req_out) else $error("reset while stopped");
    a_halt_freeze: assert property (cpu_debug_halt_in && $past(cpu_debug_halt_in) && !bus_wr_in &&
        !$past(bus_wr_in) && !sys_reset_req_out |=> !sys_reset_req_out) else $error("counting while halted");
    a_irq_mode: assert property (irq_out |-> mode_out != wdu_pkg::WDU_NORMAL &&
        mode_out != wdu_pkg::WDU_WINDOW) else $error("interrupt with warning disabled");
    a_bad_key: assert property (wr_ok && bus_addr_in == wdu_pkg::OFS_CLEAR && sw_en_reg &&
        bus_wdata_in[7:0] != wdu_pkg::CLEAR_KEY && mode_out != wdu_pkg::WDU_STOPPED |=> sys_reset_req_out)
        else $error("bad clear key without reset");
    a_flag_clear: assert property (bus_wr_in && bus_addr_in == wdu_pkg::OFS_INT_FLAG &&
        bus_wdata_in[0] && !(osc_clk_in && !$past(osc_clk_in)) |=> !irq_out) else $error("flag not cleared");
    c_reset: cover property ($rose(sys_reset_req_out));
    c_irq: cover property ($rose(irq_out));
    c_window: cover property (mode_out == wdu_pkg::WDU_WINDOW_EW);
endmodule
